// [rtl/skip_flow_alu.sv]
/*
  Eight-bit adder/subtractor producing result and the four arithmetic flags.
  Assumes purely combinational use; carry is a borrow on subtraction.
*/
`timescale 1ns/100ps
`default_nettype none
module skip_flow_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic sub,
  output logic [7:0] res,
  output logic [3:0] flags
);
  logic [8:0] full;
  logic [4:0] half;
  logic [7:0] b_eff;

  // Subtraction as a plus inverted b plus one; borrow is the inverted carry
  always_comb begin
    b_eff = sub ? ~b : b;
    full = {1'b0, a} + {1'b0, b_eff} + {8'h00, sub};
    half = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, sub};
    res = full[7:0];
    flags = 4'h0;
    flags[skip_flow_pkg::FLAG_Z] = (full[7:0] == 8'h00);
    flags[skip_flow_pkg::FLAG_C] = full[8] ^ sub;
    flags[skip_flow_pkg::FLAG_AC] = half[4] ^ sub;
    flags[skip_flow_pkg::FLAG_OV] = (a[7] == b_eff[7]) && (full[7] != a[7]);
  end
endmodule : skip_flow_alu
`default_nettype wire

// [rtl/skip_flow_exec.sv]
/*
  Executor for conditional-skip and system-control operations of a small
  8-bit core. Holds program counter, stack pointer, work register, flags and
  the global interrupt enable. Assumes the fetch stage offers one decoded
  operation per instruction cycle when instr_ready is high, and that data
  memory reads combinationally within the same cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module skip_flow_exec #(
  parameter int PC_W = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire skip_flow_pkg::op_t instr_op,
  input wire logic [7:0] instr_imm,
  input wire logic [7:0] instr_maddr,
  input wire logic [PC_W-1:0] instr_target,
  input wire logic [2:0] instr_bit,
  input wire logic [7:0] io_port_data,
  input wire logic [7:0] mem_rdata,
  input wire logic wake,
  output logic instr_ready,
  output logic [7:0] mem_addr,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic [PC_W-1:0] pc,
  output logic [7:0] sp,
  output logic [7:0] work_register,
  output logic [3:0] flags,
  output logic gie,
  output logic sys_clock_stop,
  output logic core_clock_stop
);
  typedef enum logic [3:0] {
    ST_RUN    = 4'b0001,
    ST_SECOND = 4'b0010,
    ST_SKIP   = 4'b0100,
    ST_HALT   = 4'b1000
  } state_t;

  typedef enum logic [1:0] {
    SEC_FILL = 2'h0,
    SEC_CALL = 2'h1,
    SEC_RET  = 2'h2,
    SEC_RETI = 2'h3
  } sec_t;

  state_t state_reg, state_next;
  sec_t sec_reg, sec_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic [PC_W-1:0] tgt_reg, tgt_next;
  logic [7:0] ret_lo_reg, ret_lo_next;
  logic [7:0] sp_reg, sp_next;
  logic [7:0] wr_reg, wr_next;
  logic [3:0] flags_reg, flags_next;
  logic gie_reg, gie_next;
  logic sys_stop_reg, sys_stop_next;
  logic core_stop_reg, core_stop_next;

  logic [7:0] alu_a, alu_b, alu_res;
  logic alu_sub;
  logic [3:0] alu_flags;
  logic [15:0] pc_wide;
  logic [15:0] ret_wide;
  logic [PC_W-1:0] pc_plus_one;

  skip_flow_alu u_alu (
    .a(alu_a),
    .b(alu_b),
    .sub(alu_sub),
    .res(alu_res),
    .flags(alu_flags)
  );

  // Return address laid out as two stack bytes, low byte first
  always_comb begin
    pc_plus_one = pc_reg + {{(PC_W-1){1'b0}}, 1'b1};
    pc_wide = 16'h0000;
    pc_wide[PC_W-1:0] = pc_reg;
    ret_wide = {mem_rdata, ret_lo_reg};
  end

  // Run and skip states both accept work; skip state swallows the one operation it takes
  assign instr_ready = (state_reg == ST_RUN) || (state_reg == ST_SKIP);

  // Next-state and datapath for every operation
  always_comb begin
    state_next = state_reg;
    sec_next = sec_reg;
    pc_next = pc_reg;
    tgt_next = tgt_reg;
    ret_lo_next = ret_lo_reg;
    sp_next = sp_reg;
    wr_next = wr_reg;
    flags_next = flags_reg;
    gie_next = gie_reg;
    sys_stop_next = sys_stop_reg;
    core_stop_next = core_stop_reg;
    mem_addr = instr_maddr;
    mem_we = 1'b0;
    mem_wdata = alu_res;
    alu_a = wr_reg;
    alu_b = mem_rdata;
    alu_sub = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (instr_valid) begin
          pc_next = pc_plus_one;
          case (instr_op)
            skip_flow_pkg::OP_NOP: begin
              pc_next = pc_plus_one;
            end
            skip_flow_pkg::OP_CEQ_IMM: begin
              alu_b = instr_imm;
              alu_sub = 1'b1;
              flags_next = alu_flags;
              if (alu_res == 8'h00) begin
                state_next = ST_SKIP;
              end
            end
            skip_flow_pkg::OP_CEQ_MEM: begin
              alu_sub = 1'b1;
              flags_next = alu_flags;
              if (alu_res == 8'h00) begin
                state_next = ST_SKIP;
              end
            end
            skip_flow_pkg::OP_TLO_IO: begin
              if (!io_port_data[instr_bit]) begin
                state_next = ST_SKIP;
              end
            end
            skip_flow_pkg::OP_THI_IO: begin
              if (io_port_data[instr_bit]) begin
                state_next = ST_SKIP;
              end
            end
            skip_flow_pkg::OP_TLO_MEM: begin
              if (!mem_rdata[instr_bit]) begin
                state_next = ST_SKIP;
              end
            end
            skip_flow_pkg::OP_THI_MEM: begin
              if (mem_rdata[instr_bit]) begin
                state_next = ST_SKIP;
              end
            end
            skip_flow_pkg::OP_INC_WR, skip_flow_pkg::OP_DEC_WR: begin
              alu_b = 8'h01;
              alu_sub = (instr_op == skip_flow_pkg::OP_DEC_WR);
              wr_next = alu_res;
              flags_next = alu_flags;
              if (alu_res == 8'h00) begin
                state_next = ST_SKIP;
              end
            end
            skip_flow_pkg::OP_INC_MEM, skip_flow_pkg::OP_DEC_MEM: begin
              alu_a = mem_rdata;
              alu_b = 8'h01;
              alu_sub = (instr_op == skip_flow_pkg::OP_DEC_MEM);
              mem_we = 1'b1;
              flags_next = alu_flags;
              if (alu_res == 8'h00) begin
                state_next = ST_SKIP;
              end
            end
            skip_flow_pkg::OP_CALL: begin
              // Low byte of the return address goes out now, high byte next
              mem_addr = sp_reg;
              mem_wdata = pc_plus_one[7:0];
              mem_we = 1'b1;
              tgt_next = instr_target;
              state_next = ST_SECOND;
              sec_next = SEC_CALL;
            end
            skip_flow_pkg::OP_GOTO: begin
              pc_next = instr_target;
              state_next = ST_SECOND;
              sec_next = SEC_FILL;
            end
            skip_flow_pkg::OP_RET_IMM, skip_flow_pkg::OP_RET,
            skip_flow_pkg::OP_RETI: begin
              if (instr_op == skip_flow_pkg::OP_RET_IMM) begin
                wr_next = instr_imm;
              end
              sp_next = sp_reg - skip_flow_pkg::SP_STEP;
              mem_addr = sp_reg - skip_flow_pkg::SP_STEP;
              ret_lo_next = mem_rdata;
              state_next = ST_SECOND;
              sec_next = (instr_op == skip_flow_pkg::OP_RETI) ?
                         SEC_RETI : SEC_RET;
            end
            skip_flow_pkg::OP_PCADD: begin
              pc_next = pc_reg + PC_W'(wr_reg);
              state_next = ST_SECOND;
              sec_next = SEC_FILL;
            end
            skip_flow_pkg::OP_GIE_ON: begin
              gie_next = 1'b1;
            end
            skip_flow_pkg::OP_GIE_OFF: begin
              gie_next = 1'b0;
            end
            skip_flow_pkg::OP_STOPSYS: begin
              sys_stop_next = 1'b1;
              core_stop_next = 1'b1;
              state_next = ST_HALT;
            end
            skip_flow_pkg::OP_STOPEXE: begin
              core_stop_next = 1'b1;
              state_next = ST_HALT;
            end
            default: begin
              pc_next = pc_plus_one;
            end
          endcase
        end
      end
      ST_SKIP: begin
        // Fetched operation is dropped: only the program counter moves
        if (instr_valid) begin
          pc_next = pc_plus_one;
          state_next = ST_RUN;
        end
      end
      ST_SECOND: begin
        state_next = ST_RUN;
        case (sec_reg)
          SEC_CALL: begin
            mem_addr = sp_reg + 8'h01;
            mem_wdata = pc_wide[15:8];
            mem_we = 1'b1;
            pc_next = tgt_reg;
            sp_next = sp_reg + skip_flow_pkg::SP_STEP;
          end
          SEC_RET, SEC_RETI: begin
            mem_addr = sp_reg + 8'h01;
            pc_next = ret_wide[PC_W-1:0];
            if (sec_reg == SEC_RETI) begin
              gie_next = 1'b1;
            end
          end
          default: begin
            pc_next = pc_reg;
          end
        endcase
      end
      ST_HALT: begin
        // Wake clears both clock stops and returns to run; the core keeps its state
        if (wake) begin
          sys_stop_next = 1'b0;
          core_stop_next = 1'b0;
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // Register everything; reset is synchronous
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      sec_reg <= SEC_FILL;
      pc_reg <= '0;
      tgt_reg <= '0;
      ret_lo_reg <= 8'h00;
      sp_reg <= skip_flow_pkg::SP_RESET;
      wr_reg <= skip_flow_pkg::WR_RESET;
      flags_reg <= skip_flow_pkg::FLAGS_RESET;
      gie_reg <= 1'b0;
      sys_stop_reg <= 1'b0;
      core_stop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sec_reg <= sec_next;
      pc_reg <= pc_next;
      tgt_reg <= tgt_next;
      ret_lo_reg <= ret_lo_next;
      sp_reg <= sp_next;
      wr_reg <= wr_next;
      flags_reg <= flags_next;
      gie_reg <= gie_next;
      sys_stop_reg <= sys_stop_next;
      core_stop_reg <= core_stop_next;
    end
  end

  assign pc = pc_reg;
  assign sp = sp_reg;
  assign work_register = wr_reg;
  assign flags = flags_reg;
  assign gie = gie_reg;
  assign sys_clock_stop = sys_stop_reg;
  assign core_clock_stop = core_stop_reg;
endmodule : skip_flow_exec
`default_nettype wire

// [rtl/skip_flow_pkg.sv]
/*
  Shared constants for the skip and flow-control executor: operation codes,
  flag bit positions, reset values and the cycle counts of both timings.
  Assumes the fetch/decode stage presents one decoded operation at a time.
*/
package skip_flow_pkg;

  typedef enum logic [4:0] {
    OP_NOP     = 5'h00,
    OP_CEQ_IMM = 5'h01,
    OP_CEQ_MEM = 5'h02,
    OP_TLO_IO  = 5'h03,
    OP_THI_IO  = 5'h04,
    OP_TLO_MEM = 5'h05,
    OP_THI_MEM = 5'h06,
    OP_INC_WR  = 5'h07,
    OP_DEC_WR  = 5'h08,
    OP_INC_MEM = 5'h09,
    OP_DEC_MEM = 5'h0A,
    OP_CALL    = 5'h0B,
    OP_GOTO    = 5'h0C,
    OP_RET_IMM = 5'h0D,
    OP_RET     = 5'h0E,
    OP_RETI    = 5'h0F,
    OP_PCADD   = 5'h10,
    OP_GIE_ON  = 5'h11,
    OP_GIE_OFF = 5'h12,
    OP_STOPSYS = 5'h13,
    OP_STOPEXE = 5'h14
  } op_t;

  // Flag bit positions
  localparam int FLAG_Z = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_AC = 2;
  localparam int FLAG_OV = 3;

  // Reset values
  localparam logic [7:0] SP_RESET = 8'h00;
  localparam logic [7:0] WR_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // Stack pointer step per pushed return address (two bytes)
  localparam logic [7:0] SP_STEP = 8'h02;

  // Instruction cycles for branches and taken skips
  localparam int CYCLES_LONG = 2;
  localparam int CYCLES_SHORT = 1;

endpackage : skip_flow_pkg

// [test/skip_flow_exec_chk.sv]
/*
  Port checker for the skip and flow executor, bound beside it.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module skip_flow_exec_chk #(
  parameter int PC_W = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire skip_flow_pkg::op_t instr_op,
  input wire logic [7:0] instr_maddr,
  input wire logic [PC_W-1:0] instr_target,
  input wire logic [7:0] mem_rdata,
  input wire logic instr_ready,
  input wire logic [7:0] mem_addr,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [PC_W-1:0] pc,
  input wire logic [7:0] sp,
  input wire logic [7:0] work_register,
  input wire logic [3:0] flags,
  input wire logic gie,
  input wire logic sys_clock_stop,
  input wire logic core_clock_stop
);
  logic tk;
  logic [PC_W-1:0] pc_inc;
  // Taken op and return address; skip shadows are kept off these ops
  assign tk = instr_valid && instr_ready;
  assign pc_inc = pc + 1'b1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_call_push: assert property (
    tk && instr_op == skip_flow_pkg::OP_CALL
    |-> mem_we && mem_addr == sp && mem_wdata == pc_inc[7:0]
    ##1 mem_we && mem_addr == sp + 8'h01 && !instr_ready
    ##1 sp == $past(sp, 2) + 8'h02 && pc == $past(instr_target, 2))
    else $error("call push wrong");
  a_ret_pop: assert property (
    tk && instr_op inside {skip_flow_pkg::OP_RET, skip_flow_pkg::OP_RETI,
      skip_flow_pkg::OP_RET_IMM}
    |-> mem_addr == sp - 8'h02
    ##1 !instr_ready && sp == $past(sp) - 8'h02 && mem_addr == sp + 8'h01)
    else $error("return pop wrong");
  a_reti_gie: assert property (
    tk && instr_op == skip_flow_pkg::OP_RETI |-> ##2 gie)
    else $error("gie not set after interrupt return");
  a_goto_pc: assert property (
    tk && instr_op == skip_flow_pkg::OP_GOTO |=> !instr_ready
    ##1 pc == $past(instr_target, 2) && sp == $past(sp, 2))
    else $error("goto wrong");
  a_pcadd_pc: assert property (
    tk && instr_op == skip_flow_pkg::OP_PCADD |=> !instr_ready
    ##1 pc == $past(pc, 2) + $past(work_register, 2))
    else $error("computed jump wrong");
  a_gie_off: assert property (
    tk && instr_op == skip_flow_pkg::OP_GIE_OFF |=> !gie)
    else $error("gie not cleared");
  a_flag_hold: assert property (
    tk && instr_op inside {skip_flow_pkg::OP_TLO_IO, skip_flow_pkg::OP_THI_IO,
      skip_flow_pkg::OP_TLO_MEM, skip_flow_pkg::OP_THI_MEM,
      skip_flow_pkg::OP_NOP, skip_flow_pkg::OP_PCADD}
    |=> $stable(flags))
    else $error("flags moved");
  a_ceq_wr: assert property (
    tk && instr_op inside {skip_flow_pkg::OP_CEQ_IMM, skip_flow_pkg::OP_CEQ_MEM}
    |=> $stable(work_register))
    else $error("compare changed work register");
  a_mem_step: assert property (
    tk && instr_op inside {skip_flow_pkg::OP_INC_MEM, skip_flow_pkg::OP_DEC_MEM}
    |-> mem_we && mem_addr == instr_maddr && mem_wdata == (instr_op ==
      skip_flow_pkg::OP_INC_MEM ? mem_rdata + 8'h01 : mem_rdata - 8'h01))
    else $error("memory step wrong");
  a_halt_stop: assert property (
    tk && instr_op inside {skip_flow_pkg::OP_STOPSYS, skip_flow_pkg::OP_STOPEXE}
    |=> core_clock_stop
      && sys_clock_stop == ($past(instr_op) == skip_flow_pkg::OP_STOPSYS))
    else $error("halt stops wrong");
  c_call: cover property (tk && instr_op == skip_flow_pkg::OP_CALL);
  c_reti: cover property (tk && instr_op == skip_flow_pkg::OP_RETI);
  c_ret: cover property (tk && instr_op == skip_flow_pkg::OP_RET);
  c_halt: cover property (sys_clock_stop);
endmodule : skip_flow_exec_chk
bind skip_flow_exec skip_flow_exec_chk #(.PC_W(PC_W)) chk_i (.clk, .rst_n,
  .instr_valid, .instr_op, .instr_maddr, .instr_target, .mem_rdata,
  .instr_ready, .mem_addr, .mem_we, .mem_wdata, .pc, .sp, .work_register,
  .flags, .gie, .sys_clock_stop, .core_clock_stop);
`default_nettype wire

// [test/skip_flow_exec_test.sv]
/*
  Self-checking bench for the skip and flow executor with a memory model.
  Assumes a 100 MHz clock and the synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module skip_flow_exec_test;
  logic clk = 1'b0, rst_n = 1'b0, v = 1'b0, wake = 1'b0;
  skip_flow_pkg::op_t op = skip_flow_pkg::OP_NOP;
  logic [7:0] d8 = 8'h00, io = 8'h00, rd, ma, wd, sp, wr;
  logic [9:0] pc, epc = 10'h000, r;
  logic rdy, we, gie, ss, cs;
  logic [3:0] fl;
  int err_total = 0, tests_run = 0;
  always #5 clk = ~clk;
  // One operand byte feeds immediate, address, bit index and target
  skip_flow_exec uut (.clk, .rst_n, .instr_valid(v), .instr_op(op),
    .instr_imm(d8), .instr_maddr(d8), .instr_target({2'b01, d8}),
    .instr_bit(d8[2:0]), .io_port_data(io), .mem_rdata(rd), .wake,
    .instr_ready(rdy), .mem_addr(ma), .mem_we(we), .mem_wdata(wd), .pc,
    .sp, .work_register(wr), .flags(fl), .gie, .sys_clock_stop(ss),
    .core_clock_stop(cs));
  skip_flow_mem mem (.clk, .addr(ma), .we, .wdata(wd), .rdata(rd));
  // Wide enough for the longest packed comparison, so no field is cut off
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  // Offer one op, hold it until ready, return after the taking edge
  task automatic go(input skip_flow_pkg::op_t o, input logic [7:0] d = 8'h00);
    @(negedge clk);
    op = o;
    d8 = d;
    v = 1'b1;
    while (rdy !== 1'b1) @(negedge clk);
    @(posedge clk);
    epc = epc + 10'h001;
  endtask : go
  // Drop valid and let the last op settle before looking
  task automatic rest;
    @(negedge clk);
    v = 1'b0;
    @(negedge clk);
  endtask : rest
  // Shadow op sets gie only when it is not skipped; pc steps by one each
  task automatic sk(input skip_flow_pkg::op_t o, input logic [7:0] d,
    input logic s);
    go(skip_flow_pkg::OP_GIE_OFF);
    go(o, d);
    go(skip_flow_pkg::OP_GIE_ON);
    rest;
    chk(gie, !s);
    chk(pc, epc);
  endtask : sk
  // Pulse wake and expect both stop outputs cleared
  task automatic wk;
    @(negedge clk);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    @(negedge clk);
    chk({rdy, ss, cs}, 3'b100);
  endtask : wk
  // Hang guard, far above the hundred-odd cycles the run needs
  initial begin
    #100000;
    err_total++;
    test_done;
  end
  initial begin
    mem.ram[8'h15] = 8'h01;
    mem.ram[8'h16] = 8'h00;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk({pc, fl, rdy, gie, ss, cs}, 16'h0008);
    chk({sp, wr}, 16'h0000);
    go(skip_flow_pkg::OP_NOP);
    rest;
    chk({pc, fl}, {epc, 4'h0});
    sk(skip_flow_pkg::OP_DEC_WR, 8'h00, 1'b0);
    chk({wr, fl}, {8'hFF, 4'h6});
    sk(skip_flow_pkg::OP_CEQ_IMM, 8'hFF, 1'b1);
    chk({wr, fl}, {8'hFF, 4'h1});
    sk(skip_flow_pkg::OP_CEQ_IMM, 8'h01, 1'b0);
    chk({wr, fl}, {8'hFF, 4'h0});
    sk(skip_flow_pkg::OP_INC_WR, 8'h00, 1'b1);
    chk({wr, fl}, {8'h00, 4'h7});
    sk(skip_flow_pkg::OP_DEC_MEM, 8'h15, 1'b1);
    chk({mem.ram[8'h15], fl}, {8'h00, 4'h1});
    sk(skip_flow_pkg::OP_INC_MEM, 8'h15, 1'b0);
    chk({mem.ram[8'h15], fl}, {8'h01, 4'h0});
    sk(skip_flow_pkg::OP_CEQ_MEM, 8'h16, 1'b1);
    chk({wr, fl}, {8'h00, 4'h1});
    sk(skip_flow_pkg::OP_TLO_MEM, 8'h15, 1'b1);
    sk(skip_flow_pkg::OP_THI_MEM, 8'h15, 1'b0);
    io = 8'h20;
    sk(skip_flow_pkg::OP_TLO_IO, 8'h15, 1'b0);
    sk(skip_flow_pkg::OP_TLO_IO, 8'h14, 1'b1);
    sk(skip_flow_pkg::OP_THI_IO, 8'h15, 1'b1);
    chk(fl, 4'h1);
    go(skip_flow_pkg::OP_CALL, 8'h55);
    r = epc;
    epc = 10'h155;
    rest;
    chk({sp, 6'h00, pc}, {8'h02, 6'h00, epc});
    chk({mem.ram[8'h01], mem.ram[8'h00]}, {6'h00, r});
    go(skip_flow_pkg::OP_RET_IMM, 8'h5A);
    epc = r;
    rest;
    chk({sp, wr}, 16'h005A);
    chk(pc, epc);
    // Plain return must restore pc and sp but leave interrupts off
    go(skip_flow_pkg::OP_CALL, 8'h40);
    r = epc;
    go(skip_flow_pkg::OP_RET);
    epc = r;
    rest;
    chk({sp, gie, pc}, {8'h00, 1'b0, epc});
    go(skip_flow_pkg::OP_GIE_OFF);
    go(skip_flow_pkg::OP_CALL, 8'h80);
    r = epc;
    go(skip_flow_pkg::OP_RETI);
    epc = r;
    rest;
    chk({sp, gie, pc}, {8'h00, 1'b1, epc});
    go(skip_flow_pkg::OP_GOTO, 8'hFF);
    epc = 10'h1FF;
    rest;
    chk({sp, pc}, {8'h00, epc});
    go(skip_flow_pkg::OP_PCADD);
    epc = epc + 10'h059;
    rest;
    chk(pc, epc);
    go(skip_flow_pkg::OP_STOPEXE);
    rest;
    chk({rdy, ss, cs}, 3'b001);
    wk;
    go(skip_flow_pkg::OP_STOPSYS);
    rest;
    chk({rdy, ss, cs}, 3'b011);
    wk;
    test_done;
  end
endmodule : skip_flow_exec_test
`default_nettype wire

// [test/skip_flow_mem.sv]
/*
  Data memory partner: 256 bytes, same-cycle read, write on the clock.
  Assumes the executor raises at most one write strobe per cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module skip_flow_mem (
  input wire logic clk,
  input wire logic [7:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] ram [256];
  // Combinational read, as the executor samples it in the same cycle
  assign rdata = ram[addr];
  // Plain always so the bench may preload bytes
  always @(posedge clk) begin
    if (we) begin
      ram[addr] <= wdata;
    end
  end
endmodule : skip_flow_mem
`default_nettype wire
